// ---- crb_exec.sv ----
`timescale 1ns/1ns
// What this block does
// RQ1: the OR instruction loads the accumulator with accumulator OR the nibble at the data pointer, carry untouched, one cycle.
// RQ2: the power-down instruction enters ram back-up only when the arming instruction ran immediately before it, one cycle.
// RQ3: rotate-right moves carry into bit 3 and bit 0 into carry, one cycle.
// RQ4: bit-clear zeroes the immediate-selected bit 0..3 of the nibble at the data pointer, others and carry untouched.
// RQ5: power-down without a directly preceding arm changes nothing, like a no-operation.
module crb_exec
  import crb_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic instrValid,
  input wire logic [OP_W-1:0] instrWord,
  input wire logic [DP_W-1:0] dataPointer,
  input wire logic [ACC_W-1:0] memRdata,
  input wire logic wakeUp,
  output logic [ACC_W-1:0] accOut,
  output logic carryFlag,
  output logic memWe,
  output logic [DP_W-1:0] memAddr,
  output logic [ACC_W-1:0] memWdata,
  output logic backupState,
  output logic done
);
  typedef struct packed {
    crb_state_t state;
    logic [ACC_W-1:0] acc;
    logic carry;
    logic armed;
    logic memWe;
    logic [DP_W-1:0] memAddr;
    logic [ACC_W-1:0] memWdata;
    logic backup;
    logic done;
  } crb_st_t;

  crb_st_t s_q;
  crb_st_t s_d;

  logic rstSync_n;

  logic take;
  logic isOr;
  logic isRotr;
  logic isPdown;
  logic isPdarm;
  logic isBclr;
  logic [1:0] bitSel;

  logic [ACC_W-1:0] clearMask;
  logic [ACC_W-1:0] orResult;
  logic [ACC_W-1:0] rotResult;
  logic [ACC_W-1:0] clearResult;
  logic rotCarry;

  logic [ACC_W-1:0] nextAcc;
  logic nextCarry;
  logic nextWe;
  logic [DP_W-1:0] nextAddr;
  logic [ACC_W-1:0] nextWdata;
  logic enterBackup;

  crb_rst_sync u_rst (
    .clk(clk),
    .arst_n(arst_n),
    .rstSync_n(rstSync_n)
  );

  // instructions are only taken while the core runs
  assign take = instrValid && !s_q.backup;

  // full-word compares except the masked bit-clear match; partial decode would alias other opcodes
  assign isOr = (instrWord == OP_OR);
  assign isRotr = (instrWord == OP_ROTR);
  assign isPdown = (instrWord == OP_PDOWN);
  assign isPdarm = (instrWord == OP_PDARM);
  assign isBclr = (instrWord & OP_BCLR_MASK) == OP_BCLR;

  // bit select sits in the low immediate field
  assign bitSel = instrWord[BSEL_LSB+1:BSEL_LSB];

  // old bit 0 leaves through the carry
  assign rotCarry = s_q.acc[0]; // see RQ3

  generate
    for (genvar i = 0; i < ACC_W; i++) begin : g_bit
      assign clearMask[i] = (bitSel == 2'(i)); // see RQ4
      assign orResult[i] = s_q.acc[i] | memRdata[i]; // see RQ1
      assign clearResult[i] = memRdata[i] & ~clearMask[i]; // see RQ4
      if (i == ACC_W - 1) begin : g_top
        assign rotResult[i] = s_q.carry; // see RQ3
      end else begin : g_low
        assign rotResult[i] = s_q.acc[i+1]; // see RQ3
      end
    end
  endgenerate

  // per-instruction results; the state process picks them up only when taken
  always_comb begin
    nextAcc = s_q.acc;
    nextCarry = s_q.carry;
    nextWe = 1'b0;
    nextAddr = s_q.memAddr;
    nextWdata = s_q.memWdata;
    enterBackup = 1'b0;
    case ({isBclr, isPdown, isRotr, isOr})
      4'b0001: begin
        // carry left alone on purpose
        nextAcc = orResult; // see RQ1
      end
      4'b0010: begin
        nextAcc = rotResult; // see RQ3
        nextCarry = rotCarry; // see RQ3
      end
      4'b0100: begin
        // unarmed power-down leaves everything as is, see RQ5
        enterBackup = s_q.armed; // see RQ2
      end
      4'b1000: begin
        // read-modify-write of the addressed nibble
        nextWe = 1'b1; // see RQ4
        nextAddr = dataPointer; // see RQ4
        nextWdata = clearResult; // see RQ4
      end
      default: begin
        // arming word and unknown words change no data
        nextAcc = s_q.acc;
        nextCarry = s_q.carry;
      end
    endcase
  end

  always_comb begin
    s_d = s_q;
    s_d.memWe = 1'b0;
    s_d.done = 1'b0;
    case (s_q.state)
      CRB_IDLE: begin
        if (take) begin
          s_d.state = CRB_EXEC;
          s_d.done = 1'b1;
          // arm holds only across the very next taken instruction
          s_d.armed = isPdarm; // see RQ2
          s_d.acc = nextAcc;
          s_d.carry = nextCarry;
          s_d.memWe = nextWe;
          s_d.memAddr = nextAddr;
          s_d.memWdata = nextWdata;
          if (enterBackup) begin
            s_d.state = CRB_BACKUP;
            s_d.backup = 1'b1; // see RQ2
            s_d.armed = 1'b0;
          end
        end
      end
      CRB_EXEC: begin
        if (take) begin
          s_d.done = 1'b1;
          s_d.armed = isPdarm; // see RQ2
          s_d.acc = nextAcc;
          s_d.carry = nextCarry;
          s_d.memWe = nextWe;
          s_d.memAddr = nextAddr;
          s_d.memWdata = nextWdata;
          if (enterBackup) begin
            s_d.state = CRB_BACKUP;
            s_d.backup = 1'b1; // see RQ2
            s_d.armed = 1'b0;
          end
        end else begin
          // gaps keep the arm; only a taken instruction consumes it
          s_d.state = CRB_IDLE;
        end
      end
      CRB_BACKUP: begin
        // core halted; only a wake event leaves back-up
        if (wakeUp) begin
          s_d.state = CRB_IDLE;
          s_d.backup = 1'b0;
        end
      end
      default: begin
        // illegal code: recover to a running core
        s_d.state = CRB_IDLE;
        s_d.backup = 1'b0;
        s_d.armed = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      s_q <= '{state: CRB_IDLE, acc: ACC_RST, carry: CARRY_RST, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // every output is a plain register field

  assign accOut = s_q.acc;
  assign carryFlag = s_q.carry;
  assign memWe = s_q.memWe;
  assign memAddr = s_q.memAddr;
  assign memWdata = s_q.memWdata;
  assign backupState = s_q.backup;
  assign done = s_q.done;
endmodule

// ---- crb_exec_asserts.sv ----
`timescale 1ns/1ns
module crb_exec_asserts import crb_pkg::*;(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic instrValid,
  input wire logic carryFlag,
  input wire logic memWe,
  input wire logic backupState,
  input wire logic [9:0] instrWord,
  input wire logic [3:0] memRdata,
  input wire logic [3:0] accOut,
  input wire logic [3:0] memWdata
);
  wire tk=instrValid&&!backupState;
  wire arm=tk&&instrWord==OP_PDARM;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_or_result: assert property (tk&&instrWord==OP_OR|=>
    accOut==($past(accOut)|$past(memRdata))&&$stable(carryFlag)) else $error("bad or");
  a_pdown_enter: assert property (tk&&instrWord==OP_PDOWN&&$past(arm)|=>backupState)
    else $error("no backup");
  a_pdown_noop: assert property (tk&&instrWord==OP_PDOWN&&$past(tk)&&!$past(arm)|=>
    !backupState&&!memWe&&$stable(accOut)&&$stable(carryFlag)) else $error("bad noop");
  a_rotr_result: assert property (tk&&instrWord==OP_ROTR|=>
    {accOut,carryFlag}=={$past(carryFlag),$past(accOut)}) else $error("bad rotate");
  a_bclr_write: assert property (tk&&(instrWord&OP_BCLR_MASK)==OP_BCLR|=>memWe&&
    memWdata==($past(memRdata)&~(4'h1<<$past(instrWord[1:0])))) else $error("bad clear");
endmodule
bind crb_exec crb_exec_asserts chk_u(.*);

// ---- crb_exec_bench.sv ----
`timescale 1ns/1ns
module crb_exec_bench import crb_pkg::*;;
  logic clk=0,arst_n=0,instrValid=0,wakeUp=0,carryFlag,memWe,backupState,done,cy=0,bk=0,b;
  logic [9:0] instrWord=0,w,p=0,t[5]='{OP_OR,OP_ROTR,OP_BCLR,OP_PDOWN,OP_PDARM};
  logic [7:0] dataPointer=0,memAddr;
  logic [3:0] memRdata=0,accOut,memWdata,acc=0,m;
  logic [18:0] q[$];
  wire [18:0] seen={accOut,carryFlag,memWe,memWdata&{4{memWe}},memAddr&{8{memWe}},backupState};
  int mismatches=0,samples_checked=0;
  always #4 clk=~clk;
  crb_exec dut_u(.*);
  task chk(logic [18:0] s,e);
    samples_checked++;
    mismatches+=s!==e;
    if (s!==e) $display("unexpected result exp %h seen %h",e,s);
  endtask
  task give_verdict;
    $display("checked %0d mismatches %0d",samples_checked,mismatches);
    if (mismatches==0&&samples_checked>0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task run(logic [9:0] o);
    @(negedge clk);
    m=$urandom;
    {instrValid,instrWord,memRdata,dataPointer}={1'b1,o,m,8'($urandom)};
    b=(o&OP_BCLR_MASK)==OP_BCLR;
    if (o==OP_OR) acc|=m;
    if (o==OP_ROTR) {acc,cy}={cy,acc};
    if (o==OP_PDOWN) bk=p==OP_PDARM;
    q.push_back({acc,cy,b,b?m&~(4'h1<<o[1:0]):4'h0,b?dataPointer:8'h00,bk});
    p=o;
  endtask
  always @(negedge clk) if (done===1'b1) begin
    if (q.size()==0) mismatches++; else
    chk(seen,q.pop_front());
  end
  initial begin
    m=$urandom(32'he27c12d5);
    arst_n<=#16 1'b1;
    repeat (4) @(negedge clk);
    repeat (80) begin
      w=t[$urandom%5];
      if (w==OP_BCLR) w[1:0]=$urandom;
      if (w==OP_PDOWN&&p==OP_PDARM) w=OP_OR;
      run(w);
    end
    run(OP_PDARM);
    run(OP_PDOWN);
    @(negedge clk) instrWord=OP_OR;
    @(negedge clk) {instrValid,wakeUp}=2'b01;
    @(negedge clk) wakeUp=0;
    bk=0;
    run(OP_OR);
    @(negedge clk) instrValid=0;
    for (int i=0;i<4&&q.size();i++) @(negedge clk);
    mismatches+=q.size();
    give_verdict;
  end
endmodule

// ---- crb_pkg.sv ----
package crb_pkg;
  localparam int ACC_W = 4;
  localparam int DP_W = 8;
  localparam int OP_W = 10;
  // opcodes (10-bit instruction words)
  localparam logic [9:0] OP_OR = 10'h019;
  localparam logic [9:0] OP_ROTR = 10'h01d;
  localparam logic [9:0] OP_PDOWN = 10'h002;
  localparam logic [9:0] OP_PDARM = 10'h22f;
  localparam logic [9:0] OP_BCLR = 10'h04c;
  localparam logic [9:0] OP_BCLR_MASK = 10'h3fc;
  localparam int BSEL_LSB = 0;
  localparam logic [3:0] ACC_RST = 4'h0;
  localparam logic CARRY_RST = 1'b0;
  localparam int SYNC_STAGES = 2;

  typedef enum logic [2:0] {
    CRB_IDLE = 3'b001,
    CRB_EXEC = 3'b010,
    CRB_BACKUP = 3'b100
  } crb_state_t;
endpackage

// ---- crb_rst_sync.sv ----
`timescale 1ns/1ns
module crb_rst_sync
  import crb_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  output logic rstSync_n
);
  typedef struct packed {
    logic [SYNC_STAGES-1:0] sh;
  } crb_rs_t;
  crb_rs_t r_q;
  crb_rs_t r_d;

  always_comb begin
    r_d = r_q;
    r_d.sh = {r_q.sh[SYNC_STAGES-2:0], 1'b1};
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign rstSync_n = r_q.sh[SYNC_STAGES-1];
endmodule
